//--- rtl/hcspl_pkg.sv
`default_nettype none
package hcspl_pkg;
   localparam int unsigned PORTS       = 7;
   localparam int unsigned CFG_W       = 3;
   localparam int unsigned AHB_AW      = 32;
   localparam int unsigned AHB_DW      = 32;

   // clock and high-speed blink timing
   localparam longint unsigned CLK_HZ       = 200_000_000;
   localparam longint unsigned HS_BLINK_HZ  = 1000;
   localparam int unsigned     HS_HALF_CYC  = int'(CLK_HZ / (2 * HS_BLINK_HZ));
   localparam int unsigned     DIV_W        = 17;
   localparam int unsigned     CAPTURE_WAIT = 2;

   // configuration-select encodings
   localparam logic [CFG_W-1:0] CFG_DEFAULT_STRAP = 3'h0;
   localparam logic [CFG_W-1:0] CFG_SMBUS         = 3'h1;
   localparam logic [CFG_W-1:0] CFG_BUS_POWERED   = 3'h2;
   localparam logic [CFG_W-1:0] CFG_EEPROM        = 3'h3;
   localparam logic [CFG_W-1:0] CFG_DYN_POWER     = 3'h4;
   localparam logic [CFG_W-1:0] CFG_DYN_POWER_USB = 3'h5;
   localparam logic [CFG_W-1:0] CFG_PLAIN_DEFAULT = 3'h6;
   localparam logic [CFG_W-1:0] CFG_GANGED_USB    = 3'h7;

   // decoded option flag positions
   localparam int unsigned FLAG_W      = 7;
   localparam int unsigned F_SMBUS     = 0;
   localparam int unsigned F_EEPROM    = 1;
   localparam int unsigned F_STRAP     = 2;
   localparam int unsigned F_BUS_PWR   = 3;
   localparam int unsigned F_LED_USB   = 4;
   localparam int unsigned F_DYN_PWR   = 5;
   localparam int unsigned F_GANGED    = 6;

   localparam logic [6:0] SMBUS_SLAVE_ADDR = 7'h2c;

   // register map (byte addresses)
   localparam logic [AHB_AW-1:0] OFF_CTRL   = 32'h0000_0000;
   localparam logic [AHB_AW-1:0] OFF_STATUS = 32'h0000_0004;
   localparam logic [AHB_AW-1:0] OFF_SMBUS  = 32'h0000_0008;

   // ctrl fields
   localparam int unsigned CTRL_LED_USB = 0;
   localparam logic        CTRL_RESET   = 1'b0;

   // status fields
   localparam int unsigned ST_CFG_LSB   = 0;
   localparam int unsigned ST_VALID     = 3;
   localparam int unsigned ST_FLAG_LSB  = 4;
   localparam int unsigned ST_LED_USB   = 11;
   localparam int unsigned ST_HS_PHASE  = 12;
endpackage : hcspl_pkg
`default_nettype wire

//--- rtl/hcspl_port_led.sv
// Overview of operation
// R1: capture select pins just after reset release
// R2: 000: internal defaults, straps honoured
// R3: 001: SMBus slave 0101100, straps off, registers
// R4: 010: defaults, straps, bus powered, USB LEDs
// R5: 011: EEPROM load, straps off, registers
// R6: 100: defaults, straps off, dynamic power switching
// R7: 101: dynamic power switching plus USB LEDs
// R8: 110: defaults, straps off, nothing else
// R9: 111: USB LEDs, ganged power and over-current
// R10: exactly one LED mode at a time
// R11: USB mode: green and amber, active low
// R12: USB mode shows no connection speed
// R13: speed mode uses only primary outputs
// R14: speed mode low-speed drives primary low
// R15: speed mode full-speed drives primary high
// R16: speed mode high-speed toggles at 1 kHz
// R17: speed mode tri-state when detached or suspended
// R18: shared free-running divider makes the toggle
`timescale 1ns/1ps
`default_nettype none
module hcspl_port_led #(
   parameter int unsigned HS_HALF_CYCLES = hcspl_pkg::HS_HALF_CYC
) (
   input  wire logic                          hclk,
   input  wire logic                          hresetn,
   // ahb-lite slave
   input  wire logic                          hsel,
   input  wire logic [hcspl_pkg::AHB_AW-1:0]  haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic [hcspl_pkg::AHB_DW-1:0]  hwdata,
   input  wire logic                          hready,
   output logic                               hreadyout,
   output logic      [hcspl_pkg::AHB_DW-1:0]  hrdata,
   output logic                               hresp,
   // strap pins
   input  wire logic                          cfg_source_pick_hi,
   input  wire logic                          cfg_source_pick_mid,
   input  wire logic                          cfg_source_pick_lo,
   // decoded configuration
   output logic                               cfg_valid,
   output logic                               smbus_slave_en,
   output logic      [6:0]                    smbus_slave_addr,
   output logic                               eeprom_load_en,
   output logic                               strap_options_en,
   output logic                               bus_powered,
   output logic                               dyn_power_switch,
   output logic                               ganged_power,
   output logic                               led_usb_mode,
   // port status from hub core
   input  wire logic [hcspl_pkg::PORTS-1:0]   port_attached,
   input  wire logic [hcspl_pkg::PORTS-1:0]   port_low_speed,
   input  wire logic [hcspl_pkg::PORTS-1:0]   port_high_speed,
   input  wire logic [hcspl_pkg::PORTS-1:0]   port_green_on,
   input  wire logic [hcspl_pkg::PORTS-1:0]   port_amber_on,
   input  wire logic                          hub_suspended,
   // indicator pins
   output logic      [hcspl_pkg::PORTS-1:0]   port_primary_indicator_n,
   output logic      [hcspl_pkg::PORTS-1:0]   port_primary_indicator_oe_n,
   output logic      [hcspl_pkg::PORTS-1:0]   port_secondary_indicator_n
);
   localparam int unsigned P = hcspl_pkg::PORTS;
   localparam int unsigned DW = hcspl_pkg::DIV_W;

   function automatic logic [hcspl_pkg::FLAG_W-1:0] cfg_decode(input logic [hcspl_pkg::CFG_W-1:0] c);
      logic [hcspl_pkg::FLAG_W-1:0] f;
      f = '0;
      unique case (c)
         hcspl_pkg::CFG_DEFAULT_STRAP: f[hcspl_pkg::F_STRAP] = 1'b1;             // R2
         hcspl_pkg::CFG_SMBUS:         f[hcspl_pkg::F_SMBUS] = 1'b1;             // R3
         hcspl_pkg::CFG_BUS_POWERED: begin                                        // R4
            f[hcspl_pkg::F_STRAP]   = 1'b1;
            f[hcspl_pkg::F_BUS_PWR] = 1'b1;
            f[hcspl_pkg::F_LED_USB] = 1'b1;
         end
         hcspl_pkg::CFG_EEPROM:        f[hcspl_pkg::F_EEPROM] = 1'b1;            // R5
         hcspl_pkg::CFG_DYN_POWER:     f[hcspl_pkg::F_DYN_PWR] = 1'b1;           // R6
         hcspl_pkg::CFG_DYN_POWER_USB: begin                                      // R7
            f[hcspl_pkg::F_DYN_PWR] = 1'b1;
            f[hcspl_pkg::F_LED_USB] = 1'b1;
         end
         hcspl_pkg::CFG_PLAIN_DEFAULT: f = '0;                                   // R8
         hcspl_pkg::CFG_GANGED_USB: begin                                         // R9
            f[hcspl_pkg::F_LED_USB] = 1'b1;
            f[hcspl_pkg::F_GANGED]  = 1'b1;
         end
      endcase
      return f;
   endfunction : cfg_decode

   // strap capture: two-flop sync, then one capture shortly after release
   logic [2:0] cfg_meta_reg;
   logic [2:0] cfg_sync_reg;
   logic [2:0] cfg_cap_reg;
   logic       valid_reg;
   logic [1:0] wait_reg;
   wire  logic capture_now = !valid_reg && (wait_reg == 2'(hcspl_pkg::CAPTURE_WAIT));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_meta_reg <= 3'h0;
         cfg_sync_reg <= 3'h0;
      end else begin
         cfg_meta_reg <= {cfg_source_pick_hi, cfg_source_pick_mid, cfg_source_pick_lo};
         cfg_sync_reg <= cfg_meta_reg;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wait_reg    <= 2'h0;
         valid_reg   <= 1'b0;
         cfg_cap_reg <= 3'h0;
      end else begin
         if (!valid_reg && !capture_now)
            wait_reg <= wait_reg + 2'h1;
         if (capture_now) begin                                                   // R1
            valid_reg   <= 1'b1;
            cfg_cap_reg <= cfg_sync_reg;
         end
      end
   end

   // ahb-lite slave, zero wait states
   logic                          ctrl_led_usb_reg;
   logic                          wr_pend_reg;
   logic [hcspl_pkg::AHB_AW-1:0]  wr_addr_reg;
   logic [hcspl_pkg::AHB_DW-1:0]  rdata_reg;
   wire  logic addr_phase   = hsel && hready && htrans[1];
   wire  logic ctrl_wr      = wr_pend_reg && (wr_addr_reg == hcspl_pkg::OFF_CTRL);
   // forward a write in its data phase so a back-to-back read sees it
   wire  logic ctrl_led_usb_next = ctrl_wr ? hwdata[hcspl_pkg::CTRL_LED_USB] : ctrl_led_usb_reg;

   wire  logic [hcspl_pkg::FLAG_W-1:0] flags = valid_reg ? cfg_decode(cfg_cap_reg) : '0;
   // LED mode under register control in select modes 000, 001, 011, 100 and 110; a forced USB mode wins
   wire  logic led_usb   = flags[hcspl_pkg::F_LED_USB] || ctrl_led_usb_reg;             // R10
   logic       hs_phase_reg;

   wire  logic [hcspl_pkg::AHB_DW-1:0] status_word =
      {19'h0, hs_phase_reg, led_usb, flags, valid_reg, cfg_cap_reg};
   wire  logic [hcspl_pkg::AHB_DW-1:0] rd_mux =
      (haddr == hcspl_pkg::OFF_CTRL)   ? {31'h0, ctrl_led_usb_next} :
      (haddr == hcspl_pkg::OFF_STATUS) ? status_word :
      (haddr == hcspl_pkg::OFF_SMBUS)  ? {25'h0, hcspl_pkg::SMBUS_SLAVE_ADDR} :
      32'h0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg      <= 1'b0;
         wr_addr_reg      <= '0;
         rdata_reg        <= '0;
         ctrl_led_usb_reg <= hcspl_pkg::CTRL_RESET;
      end else begin
         wr_pend_reg      <= addr_phase && hwrite;
         wr_addr_reg      <= haddr;
         ctrl_led_usb_reg <= ctrl_led_usb_next;
         if (addr_phase && !hwrite)
            rdata_reg <= rd_mux;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_reg;

   assign cfg_valid        = valid_reg;
   assign smbus_slave_en   = flags[hcspl_pkg::F_SMBUS];
   assign smbus_slave_addr = hcspl_pkg::SMBUS_SLAVE_ADDR;
   assign eeprom_load_en   = flags[hcspl_pkg::F_EEPROM];
   assign strap_options_en = flags[hcspl_pkg::F_STRAP];
   assign bus_powered      = flags[hcspl_pkg::F_BUS_PWR];
   assign dyn_power_switch = flags[hcspl_pkg::F_DYN_PWR];
   assign ganged_power     = flags[hcspl_pkg::F_GANGED];
   assign led_usb_mode     = led_usb;

   // one shared divider so all ports blink in phase
   logic [hcspl_pkg::DIV_W-1:0] div_reg;
   wire  logic div_wrap = (div_reg == DW'(HS_HALF_CYCLES - 1));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_reg      <= '0;
         hs_phase_reg <= 1'b0;
      end else begin
         div_reg      <= div_wrap ? '0 : div_reg + DW'(1);                        // R18
         if (div_wrap)
            hs_phase_reg <= !hs_phase_reg;                                         // R16
      end
   end

   genvar g;
   generate
      for (g = 0; g < P; g++) begin : g_port
         wire logic lit = port_attached[g] && !hub_suspended;
         // speed colour: low first, then high, otherwise full
         wire logic spd_lvl = port_low_speed[g]  ? 1'b0 :                         // R14
                              port_high_speed[g] ? hs_phase_reg :                 // R16
                              1'b1;                                               // R15
         wire logic prim_next = !valid_reg ? 1'b1 :
                                led_usb    ? !port_green_on[g] : spd_lvl;         // R11 R12
         wire logic oe_n_next = !valid_reg ? 1'b1 :
                                led_usb    ? 1'b0 : !lit;                         // R17
         wire logic sec_next  = !valid_reg || !led_usb || !port_amber_on[g];      // R13

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               port_primary_indicator_n[g]    <= 1'b1;
               port_primary_indicator_oe_n[g] <= 1'b1;
               port_secondary_indicator_n[g]  <= 1'b1;
            end else begin
               port_primary_indicator_n[g]    <= prim_next;
               port_primary_indicator_oe_n[g] <= oe_n_next;
               port_secondary_indicator_n[g]  <= sec_next;
            end
         end

         low_speed_led_a: assert property (@(posedge hclk) disable iff (!hresetn) // R14
            valid_reg && !led_usb && lit && port_low_speed[g]
            |=> !port_primary_indicator_n[g] && !port_primary_indicator_oe_n[g])
            else $error("low-speed port not driven low");
         full_speed_led_a: assert property (@(posedge hclk) disable iff (!hresetn) // R15
            valid_reg && !led_usb && lit && !port_low_speed[g] && !port_high_speed[g]
            |=> port_primary_indicator_n[g] && !port_primary_indicator_oe_n[g])
            else $error("full-speed port not driven high");
         off_state_a: assert property (@(posedge hclk) disable iff (!hresetn)    // R17
            valid_reg && !led_usb && !lit |=> port_primary_indicator_oe_n[g])
            else $error("idle port not tri-stated");
         usb_amber_a: assert property (@(posedge hclk) disable iff (!hresetn)    // R11
            valid_reg && led_usb
            |=> port_secondary_indicator_n[g] == !$past(port_amber_on[g])
                && !port_primary_indicator_oe_n[g])
            else $error("amber output does not follow request");
         // usb mode mirrors the hub core's request bits, speed inputs unused
         secondary_off_a: assert property (@(posedge hclk) disable iff (!hresetn) // R13
            valid_reg && !led_usb |=> port_secondary_indicator_n[g])
            else $error("secondary output lit in speed mode");
         usb_green_a: assert property (@(posedge hclk) disable iff (!hresetn)     // R12
            valid_reg && led_usb
            |=> port_primary_indicator_n[g] == !$past(port_green_on[g]))
            else $error("green output does not follow request");
         high_speed_led_a: assert property (@(posedge hclk) disable iff (!hresetn) // R16
            valid_reg && !led_usb && lit && !port_low_speed[g] && port_high_speed[g]
            |=> port_primary_indicator_n[g] == $past(hs_phase_reg) && !port_primary_indicator_oe_n[g])
            else $error("high-speed port not blinking");
      end
   endgenerate

   cfg_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)          // R1
      valid_reg |=> valid_reg && $stable(cfg_cap_reg))
      else $error("captured select changed after capture");
   cfg_when_a: assert property (@(posedge hclk) disable iff (!hresetn)          // R1
      $rose(valid_reg) |-> cfg_cap_reg == $past(cfg_sync_reg) && $past(wait_reg) == 2'h2)
      else $error("select captured at wrong time");
   smbus_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)        // R3
      valid_reg && cfg_cap_reg == hcspl_pkg::CFG_SMBUS
      |-> smbus_slave_en && !strap_options_en && !eeprom_load_en && smbus_slave_addr == 7'h2c)
      else $error("smbus mode decode wrong");
   eeprom_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)       // R5
      valid_reg && cfg_cap_reg == hcspl_pkg::CFG_EEPROM
      |-> eeprom_load_en && !strap_options_en && !smbus_slave_en)
      else $error("eeprom mode decode wrong");
   bus_power_a: assert property (@(posedge hclk) disable iff (!hresetn)         // R4
      valid_reg && cfg_cap_reg == hcspl_pkg::CFG_BUS_POWERED
      |-> bus_powered && strap_options_en && led_usb_mode)
      else $error("bus-powered decode wrong");
   ganged_usb_a: assert property (@(posedge hclk) disable iff (!hresetn)        // R9
      valid_reg && cfg_cap_reg == hcspl_pkg::CFG_GANGED_USB
      |-> ganged_power && led_usb_mode && !strap_options_en && !dyn_power_switch)
      else $error("ganged decode wrong");
   dyn_power_a: assert property (@(posedge hclk) disable iff (!hresetn)         // R6
      valid_reg && cfg_cap_reg[2:1] == 2'h2 |-> dyn_power_switch && !strap_options_en)
      else $error("dynamic power decode wrong");
   hs_toggle_a: assert property (@(posedge hclk) disable iff (!hresetn)         // R16
      $changed(hs_phase_reg) |-> $past(div_reg) == DW'(HS_HALF_CYCLES - 1))
      else $error("blink toggled off its period");
   div_step_a: assert property (@(posedge hclk) disable iff (!hresetn)          // R18
      div_reg != '0 |-> div_reg == $past(div_reg) + DW'(1))
      else $error("blink divider skipped a count");
   pre_capture_off_a: assert property (@(posedge hclk) disable iff (!hresetn)   // R1
      !valid_reg |=> (&port_primary_indicator_oe_n) && (&port_secondary_indicator_n))
      else $error("indicators active before select capture");
   // decode checks: 000 and 110 against every option but LED mode, then 101 and forced USB mode
   decode_strap_a: assert property (@(posedge hclk) disable iff (!hresetn)      // R2
      valid_reg && cfg_cap_reg == hcspl_pkg::CFG_DEFAULT_STRAP
      |-> strap_options_en && !smbus_slave_en && !eeprom_load_en
          && !bus_powered && !dyn_power_switch && !ganged_power)
      else $error("default strap decode wrong");
   decode_plain_a: assert property (@(posedge hclk) disable iff (!hresetn)      // R8
      valid_reg && cfg_cap_reg == hcspl_pkg::CFG_PLAIN_DEFAULT
      |-> !strap_options_en && !smbus_slave_en && !eeprom_load_en
          && !bus_powered && !dyn_power_switch && !ganged_power)
      else $error("plain default decode wrong");
   dyn_usb_a: assert property (@(posedge hclk) disable iff (!hresetn)           // R7
      valid_reg && cfg_cap_reg == hcspl_pkg::CFG_DYN_POWER_USB
      |-> dyn_power_switch && led_usb_mode && !strap_options_en)
      else $error("dynamic power usb decode wrong");
   mode_forced_a: assert property (@(posedge hclk) disable iff (!hresetn)       // R10
      valid_reg && (cfg_cap_reg == hcspl_pkg::CFG_BUS_POWERED || cfg_cap_reg == hcspl_pkg::CFG_DYN_POWER_USB
                    || cfg_cap_reg == hcspl_pkg::CFG_GANGED_USB) |-> led_usb_mode)
      else $error("select did not force usb led mode");
endmodule : hcspl_port_led
`default_nettype wire

//--- verification/hcspl_board.sv
`timescale 1ns/1ps
`default_nettype none
module hcspl_board (
   input  wire logic [6:0] primary_n,
   input  wire logic [6:0] primary_oe_n,
   input  wire logic [2:0] strap_value,
   output logic            pick_hi,
   output logic            pick_mid,
   output logic            pick_lo,
   output logic      [6:0] led_level
);
   logic [6:0] last_level;
   // straps come from board resistors, steady across reset release
   assign pick_hi  = strap_value[2];
   assign pick_mid = strap_value[1];
   assign pick_lo  = strap_value[0];
   always @(primary_n or primary_oe_n) begin
      for (int i = 0; i < 7; i++) begin
         if (primary_oe_n[i] === 1'b0) begin
            last_level[i] = primary_n[i];
         end
      end
   end
   // a floating pin shows the inverse of its last drive so stale data never matches
   assign led_level = (~primary_oe_n & primary_n) | (primary_oe_n & ~last_level);
endmodule : hcspl_board
`default_nettype wire

//--- verification/hcspl_port_led_test.sv
`timescale 1ns/1ps
`default_nettype none
module hcspl_port_led_test;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, hready, hreadyout, hresp;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  strap = 3'h0;
   logic        p_hi, p_mid, p_lo, cfg_valid, sm_en, ee_en, st_en, bus_pw, dyn_pw, gang_pw, usb_md;
   logic [6:0]  sm_addr, att = 7'h0, low = 7'h0, high = 7'h0, green = 7'h0, amber = 7'h0;
   logic [6:0]  prim_n, oe_n, sec_n, led_level, flags;
   logic        susp = 1'b0, prev;
   int          err_total = 0, checks_done = 0, hi, ch;
   logic [6:0]  exp_flags [8] = '{7'h04, 7'h01, 7'h1c, 7'h02, 7'h20, 7'h30, 7'h00, 7'h50};
   assign hready = hreadyout;
   assign flags = {gang_pw, dyn_pw, usb_md, bus_pw, st_en, ee_en, sm_en};
   always #2.5 hclk = ~hclk;
   hcspl_port_led #(.HS_HALF_CYCLES(8)) hcspl_port_led_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .cfg_source_pick_hi(p_hi), .cfg_source_pick_mid(p_mid), .cfg_source_pick_lo(p_lo),
      .cfg_valid(cfg_valid), .smbus_slave_en(sm_en), .smbus_slave_addr(sm_addr), .eeprom_load_en(ee_en),
      .strap_options_en(st_en), .bus_powered(bus_pw), .dyn_power_switch(dyn_pw), .ganged_power(gang_pw),
      .led_usb_mode(usb_md), .port_attached(att), .port_low_speed(low), .port_high_speed(high),
      .port_green_on(green), .port_amber_on(amber), .hub_suspended(susp),
      .port_primary_indicator_n(prim_n), .port_primary_indicator_oe_n(oe_n),
      .port_secondary_indicator_n(sec_n));
   hcspl_board hcspl_board_inst (
      .primary_n(prim_n), .primary_oe_n(oe_n), .strap_value(strap),
      .pick_hi(p_hi), .pick_mid(p_mid), .pick_lo(p_lo), .led_level(led_level));
   task automatic summarize;
      if (err_total == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask : chk
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            err_total++;
            summarize();
         end
         @(posedge hclk);
      end
   endtask : wait_rdy
   task automatic ahb_xfer(input logic [31:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask : ahb_xfer
   task automatic do_reset(input logic [2:0] v);
      int n;
      @(posedge hclk);
      hresetn <= 1'b0;
      strap <= v;
      repeat (8) @(posedge hclk);
      #1;
      chk({cfg_valid, flags, oe_n, sec_n, prim_n, hreadyout}, {1'b0, 7'h00, 7'h7f, 7'h7f, 7'h7f, 1'b1});
      chk(hrdata, 32'h0);
      chk(hresp, 32'h0);
      @(posedge hclk);
      hresetn <= 1'b1;
      n = 0;
      while (cfg_valid !== 1'b1) begin
         n++;
         if (n > 20) begin
            err_total++;
            summarize();
         end
         @(posedge hclk);
      end
   endtask : do_reset
   initial begin
      for (int r = 0; r < 8; r++) begin
         do_reset(3'(r));
         chk(flags, exp_flags[r]);
         ahb_xfer(hcspl_pkg::OFF_STATUS, 1'b0, 32'h0, rd);
         chk(rd[11:0], {exp_flags[r][4], exp_flags[r], 1'b1, 3'(r)});
      end
      chk(sm_addr, 7'h2c);
      do_reset(3'h0);
      strap <= 3'h7;
      repeat (10) @(posedge hclk);
      chk(flags, 7'h04);
      // port1 low, port2 full, port3 high, port4 low and high, others empty
      att <= 7'h0f;
      low <= 7'h09;
      high <= 7'h0c;
      green <= 7'h2a;
      amber <= 7'h55;
      repeat (2) @(posedge hclk);
      #1;
      chk(oe_n, 7'h70);
      chk(sec_n, 7'h7f);
      chk({led_level[3], led_level[1], led_level[0]}, 3'h2);
      prev = led_level[2];
      hi = 0;
      ch = 0;
      repeat (32) begin
         @(posedge hclk);
         #1;
         hi += int'(led_level[2]);
         ch += int'(led_level[2] !== prev);
         prev = led_level[2];
      end
      chk(hi, 16);
      chk(ch, 4);
      susp <= 1'b1;
      repeat (2) @(posedge hclk);
      #1;
      chk(oe_n, 7'h7f);
      susp <= 1'b0;
      ahb_xfer(hcspl_pkg::OFF_CTRL, 1'b1, 32'h1, rd);
      ahb_xfer(hcspl_pkg::OFF_CTRL, 1'b0, 32'h0, rd);
      chk(rd, 32'h1);
      repeat (2) @(posedge hclk);
      #1;
      chk({usb_md, oe_n}, {1'b1, 7'h00});
      chk({prim_n, sec_n}, {7'h55, 7'h2a});
      ahb_xfer(32'h0000_000c, 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
      ahb_xfer(hcspl_pkg::OFF_STATUS, 1'b1, 32'hffff_ffff, rd);
      ahb_xfer(hcspl_pkg::OFF_STATUS, 1'b0, 32'h0, rd);
      chk(rd[11:0], {1'b1, 7'h04, 1'b1, 3'h0});
      ahb_xfer(hcspl_pkg::OFF_SMBUS, 1'b0, 32'h0, rd);
      chk(rd, 32'h2c);
      ahb_xfer(hcspl_pkg::OFF_CTRL, 1'b1, 32'h0, rd);
      repeat (3) @(posedge hclk);
      #1;
      chk({usb_md, sec_n, oe_n}, {1'b0, 7'h7f, 7'h70});
      summarize();
   end
endmodule : hcspl_port_led_test
`default_nettype wire
